// >>> rtl/receiver_power_on_off_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module receiver_power_on_off_sequencer #(
    parameter int unsigned TOGGLE_MIN = seq_pkg::TOGGLE_MIN_CYC,
    parameter int unsigned SHUT_LIMIT = seq_pkg::SHUTDOWN_CYC,
    parameter int unsigned BOOT_TIME  = seq_pkg::BOOT_CYC
) (
    input  wire logic mclk,              // 100 MHz clock
    input  wire logic srst,              // sync reset, power-up
    input  wire logic toggle_pin,        // power toggle pin, async
    input  wire logic uart_mode,         // strap: serial messages on
    input  wire logic shutdown_msg,      // pulse: shutdown message decoded
    input  wire logic write_pending,     // critical write still busy
    input  wire logic antenna_need,      // rf section wants antenna bias
    output logic      digital_on_status, // high while operational
    output logic      run_enable,        // internal operation enabled
    output logic      msg_enable,        // serial messages may be sent
    output logic      flush_req,         // commit data to backup stores
    output logic      antenna_bias_en,   // antenna supply switch
    output logic      shutdown_done      // level: safe to lose supply
);
    logic                     seen;
    logic                     pend_s1;
    logic                     pend_s2;
    seq_pkg::pwr_state_t      state;
    seq_pkg::pwr_state_t      next_state;
    logic [seq_pkg::CNT_W-1:0] cnt;
    logic [seq_pkg::CNT_W-1:0] next_cnt;
    logic                     next_on;
    logic                     next_run;
    logic                     next_msg;
    logic                     next_flush;
    logic                     next_ant;
    logic                     next_done;

    // ==================================================================
    // toggle pin qualification
    toggle_filter #(
        .MIN_CYC    (TOGGLE_MIN)
    ) u_filter (
        .mclk       (mclk),
        .srst       (srst),
        .pin        (toggle_pin),
        .pulse_seen (seen)
    );

    // ==================================================================
    // sequencer next values
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            seq_pkg::st_off: begin
                next_cnt = '0;
                if (seen) begin
                    next_state = seq_pkg::st_boot;
                end
            end
            seq_pkg::st_boot: begin
                next_cnt = cnt + 1'b1;
                if (cnt >= BOOT_TIME[seq_pkg::CNT_W-1:0]) begin
                    next_state = seq_pkg::st_run;
                end
            end
            seq_pkg::st_run: begin
                next_cnt = '0;
                if (seen || shutdown_msg) begin
                    next_state = seq_pkg::st_flush;
                end
            end
            seq_pkg::st_flush: begin
                // finish pending writes, bounded by the limit; wait out
                // the synchroniser lag so a just-raised request is seen
                next_cnt = cnt + 1'b1;
                if ((!pend_s2 &&
                     cnt >= seq_pkg::CNT_W'(seq_pkg::PEND_SETTLE_CYC)) ||
                    cnt >= SHUT_LIMIT[seq_pkg::CNT_W-1:0] - 2) begin
                    next_state = seq_pkg::st_halt;
                end
            end
            seq_pkg::st_halt: begin
                // dormant; a new toggle restarts
                next_cnt = '0;
                if (seen) begin
                    next_state = seq_pkg::st_boot;
                end
            end
            default: begin
                next_state = seq_pkg::st_off;
                next_cnt   = '0;
            end
        endcase
        // outputs decoded from the coming state
        next_on    = (next_state == seq_pkg::st_run);
        next_run   = (next_state == seq_pkg::st_run) ||
                     (next_state == seq_pkg::st_boot);
        next_msg   = (next_state == seq_pkg::st_run) && uart_mode;
        next_flush = (next_state == seq_pkg::st_flush);
        next_ant   = (next_state == seq_pkg::st_run) && antenna_need;
        next_done  = (next_state == seq_pkg::st_halt) ||
                     (next_state == seq_pkg::st_off);
    end

    // ==================================================================
    // registers; write_pending synchronised as it comes from elsewhere
    always_ff @(posedge mclk) begin
        if (srst) begin
            state             <= seq_pkg::st_off;
            cnt               <= '0;
            pend_s1           <= 1'b0;
            pend_s2           <= 1'b0;
            digital_on_status <= 1'b0;
            run_enable        <= 1'b0;
            msg_enable        <= 1'b0;
            flush_req         <= 1'b0;
            antenna_bias_en   <= 1'b0;
            shutdown_done     <= 1'b1;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            pend_s1           <= write_pending;
            pend_s2           <= pend_s1;
            digital_on_status <= next_on;
            run_enable        <= next_run;
            msg_enable        <= next_msg;
            flush_req         <= next_flush;
            antenna_bias_en   <= next_ant;
            shutdown_done     <= next_done;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/seq_pkg.sv
package seq_pkg;
    // ==================================================================
    // timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TOGGLE_PULSE_MS = 200;   // nominal toggle pulse
    localparam int unsigned SHUTDOWN_MAX_MS = 1000;  // shutdown limit
    localparam int unsigned BOOT_MS         = 10;    // internal boot time
    // least toggle width accepted: half the nominal pulse, rounded down
    localparam int unsigned TOGGLE_MIN_CYC  =
        (CLK_HZ / 1000) * (TOGGLE_PULSE_MS / 2);
    localparam int unsigned SHUTDOWN_CYC    =
        (CLK_HZ / 1000) * SHUTDOWN_MAX_MS;
    localparam int unsigned BOOT_CYC        = (CLK_HZ / 1000) * BOOT_MS;
    localparam int unsigned CNT_W           = 32;
    // flush cycles before the synchronised pending flag can be trusted
    localparam int unsigned PEND_SETTLE_CYC = 2;

    // ==================================================================
    // power states
    typedef enum logic [2:0] {
        st_off,
        st_boot,
        st_run,
        st_flush,
        st_halt
    } pwr_state_t;
endpackage

// >>> rtl/toggle_filter.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// synchronises the toggle pin and flags a high pulse of enough width
module toggle_filter #(
    parameter int unsigned MIN_CYC = 20_000_000
) (
    input  wire logic mclk,       // system clock
    input  wire logic srst,       // sync reset
    input  wire logic pin,        // raw toggle pin
    output logic      pulse_seen  // one cycle on falling edge of good pulse
);
    logic        sync_a;
    logic        sync_b;
    logic        prev;
    logic [31:0] width;
    logic        next_prev;
    logic [31:0] next_width;
    logic        next_seen;

    // next values: width counter and falling-edge qualification
    always_comb begin
        next_prev  = sync_b;
        next_seen  = 1'b0;
        next_width = width;
        if (sync_b) begin
            if (width != 32'hFFFFFFFF) begin
                next_width = width + 32'h00000001;
            end
        end else begin
            next_width = 32'h00000000;
            if (prev && (width >= MIN_CYC)) begin
                next_seen = 1'b1;
            end
        end
    end

    // registers; two-stage pin synchroniser first
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_a     <= 1'b0;
            sync_b     <= 1'b0;
            prev       <= 1'b0;
            width      <= 32'h00000000;
            pulse_seen <= 1'b0;
        end else begin
            sync_a     <= pin;
            sync_b     <= sync_a;
            prev       <= next_prev;
            width      <= next_width;
            pulse_seen <= next_seen;
        end
    end
endmodule
`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host pulsing the toggle pin
module host_model (
    input  wire logic       mclk,       // clock
    input  wire logic       go,         // start a pulse
    input  wire logic [7:0] width,      // pulse cycles
    output logic            toggle_pin  // toggle drive
);
    logic [7:0] cnt = 8'h00;
    // pulse timer, requests ignored while busy
    always @(posedge mclk) cnt <= (cnt != 8'h00) ? cnt - 8'h01 : (go ? width : 8'h00);
    assign toggle_pin = (cnt != 8'h00);
endmodule
`default_nettype wire

// >>> verif/receiver_power_on_off_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
module receiver_power_on_off_sequencer_test;
    logic mclk = 1'b0, srst = 1'b1, uart_mode = 1'b1, shutdown_msg = 1'b0, go = 1'b0;
    logic write_pending = 1'b0, antenna_need = 1'b0, toggle_pin, digital_on_status;
    logic run_enable, msg_enable, flush_req, antenna_bias_en, shutdown_done;
    logic [7:0] width = 8'h06;
    int mismatches = 0, cmp_count = 0, i;
    // clock
    always #5 mclk = ~mclk;
    host_model HOST (.mclk(mclk), .go(go), .width(width), .toggle_pin(toggle_pin));
    receiver_power_on_off_sequencer #(.TOGGLE_MIN(4), .SHUT_LIMIT(40), .BOOT_TIME(5)) DUT (
        .mclk(mclk), .srst(srst), .toggle_pin(toggle_pin), .uart_mode(uart_mode),
        .shutdown_msg(shutdown_msg), .write_pending(write_pending),
        .antenna_need(antenna_need), .digital_on_status(digital_on_status),
        .run_enable(run_enable), .msg_enable(msg_enable), .flush_req(flush_req),
        .antenna_bias_en(antenna_bias_en), .shutdown_done(shutdown_done));
    task check(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task pulse(input logic [7:0] w);
        @(posedge mclk) go <= 1'b1;
        width <= w;
        @(posedge mclk) go <= 1'b0;
        repeat (w + 6) @(negedge mclk);
    endtask
    task t_short;
        pulse(8'h02);
        check("run_enable", 1'b0, run_enable);
        check("shutdown_done", 1'b1, shutdown_done);
    endtask
    task t_start(input logic uart);
        @(posedge mclk) uart_mode <= uart;
        antenna_need <= 1'b0;
        pulse(8'h06);
        check("run_enable", 1'b1, run_enable);
        check("status", 1'b0, digital_on_status);
        for (i = 0; i < 20 && digital_on_status !== 1'b1; i++) @(negedge mclk);
        check("status", 1'b1, digital_on_status);
        check("msg_enable", uart, msg_enable);
        check("antenna_bias_en", 1'b0, antenna_bias_en);
        @(posedge mclk) antenna_need <= 1'b1;
        repeat (3) @(negedge mclk);
        check("antenna_bias_en", 1'b1, antenna_bias_en);
    endtask
    task t_shut_msg;
        @(posedge mclk) write_pending <= 1'b1;
        shutdown_msg <= 1'b1;
        @(posedge mclk) shutdown_msg <= 1'b0;
        @(negedge mclk);
        check("flush_req", 1'b1, flush_req);
        check("antenna_bias_en", 1'b0, antenna_bias_en);
        repeat (10) @(negedge mclk);
        check("flush_req", 1'b1, flush_req);
        @(posedge mclk) write_pending <= 1'b0;
        for (i = 0; i < 8 && shutdown_done !== 1'b1; i++) @(negedge mclk);
        check("shutdown_done", 1'b1, shutdown_done);
        check("flush_req", 1'b0, flush_req);
        // shutdown message outside run is ignored
        @(posedge mclk) shutdown_msg <= 1'b1;
        @(posedge mclk) shutdown_msg <= 1'b0;
        repeat (2) @(negedge mclk);
        check("flush_req", 1'b0, flush_req);
        check("shutdown_done", 1'b1, shutdown_done);
    endtask
    // write_pending held high through the whole flush, so the limit ends it
    task t_shut_toggle;
        @(posedge mclk) write_pending <= 1'b1;
        pulse(8'h06);
        check("flush_req", 1'b1, flush_req);
        for (i = 0; i < 40 && shutdown_done !== 1'b1; i++) @(negedge mclk);
        check("shutdown_done", 1'b1, shutdown_done);
        @(posedge mclk) write_pending <= 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_short;
        t_start(1'b1);
        t_shut_msg;
        t_start(1'b0);
        t_shut_toggle;
        wrap_up;
    end
    // watchdog
    initial begin
        #20000;
        mismatches++;
        wrap_up;
    end
endmodule
`default_nettype wire

// >>> verif/seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// sequencer output checks
module seq_asserts #(
    parameter int unsigned SHUT_LIMIT = 40
) (
    input wire logic mclk, srst, uart_mode, shutdown_msg, antenna_need,
    input wire logic digital_on_status, run_enable, msg_enable,
    input wire logic flush_req, antenna_bias_en, shutdown_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [31:0] flush_cnt;
    // cycles spent flushing
    always_ff @(posedge mclk) flush_cnt <= flush_req ? flush_cnt + 32'h1 : 32'h0;
    property p_bias_off; antenna_bias_en |-> digital_on_status; endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias outside run");
    property p_bias_need; digital_on_status && $past(digital_on_status)
        && $stable(antenna_need) |-> antenna_bias_en == antenna_need; endproperty
    a_bias_need: assert property (p_bias_need) else $error("bias wrong");
    property p_msg; digital_on_status && $past(digital_on_status)
        && $stable(uart_mode) |-> msg_enable == uart_mode; endproperty
    a_msg: assert property (p_msg) else $error("msg enable wrong");
    property p_status; digital_on_status |-> run_enable && !flush_req
        && !shutdown_done; endproperty
    a_status: assert property (p_status) else $error("status high wrongly");
    property p_shut_msg; digital_on_status && shutdown_msg |=> flush_req
        && !digital_on_status && !antenna_bias_en && !msg_enable; endproperty
    a_shut_msg: assert property (p_shut_msg) else $error("no shutdown");
    property p_flush; flush_req |-> !run_enable && !shutdown_done; endproperty
    a_flush: assert property (p_flush) else $error("flush while running");
    property p_flush_len; flush_cnt <= SHUT_LIMIT; endproperty
    a_flush_len: assert property (p_flush_len) else $error("flush too long");
    property p_done; $fell(flush_req) |-> shutdown_done; endproperty
    a_done: assert property (p_done) else $error("flush end not done");
endmodule
bind receiver_power_on_off_sequencer seq_asserts #(.SHUT_LIMIT(SHUT_LIMIT)) chk (
    .mclk(mclk), .srst(srst), .uart_mode(uart_mode), .shutdown_msg(shutdown_msg),
    .antenna_need(antenna_need), .digital_on_status(digital_on_status),
    .run_enable(run_enable), .msg_enable(msg_enable), .flush_req(flush_req),
    .antenna_bias_en(antenna_bias_en), .shutdown_done(shutdown_done));
`default_nettype wire
